//--- hdl/bat_core.sv
`timescale 1ns/1ps
`include "bat_params.svh"
// Functional notes
// - aborted bus cycle leaves internal state untouched
// - aborted read answers all ones, writes dropped silently
// - serial read abort holds output high until deselect
// - serial write abort drives high, drops data
// - wait states allowed while decoding before abort
// - failure mode: measurement writes accepted, no action
// - failure mode keeps registers and locality working
// - duration starts at start-bit write of one
// - fifo completion sets both ready flags
// - buffer completion clears start bit
// - measurement duration: address to deselect
// - measurement data timed for one 64-byte block
// - commands bounded by nominal and timeout limits
// - large signature keys exempt from limits
module bat_core import bat_pkg::*; #(
  parameter int unsigned MS_CYCLES = `BAT_MS_CYCLES
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // serial pins
  input  wire logic        spi_sck,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_mosi,
  output logic             spi_miso_o,
  output logic             spi_miso_oe_n,
  // serial decode
  input  wire logic        decode_wait,
  input  wire logic        abort_req,
  input  wire logic [7:0]  rd_byte,
  output logic [7:0]       wr_byte,
  output logic             wr_byte_vld,
  // parallel bus cycle
  input  wire logic        lpc_cycle_end,
  input  wire logic        lpc_abort,
  input  wire logic        lpc_is_read,
  input  wire logic [7:0]  lpc_wdata,
  input  wire logic [7:0]  lpc_rdata,
  output logic             lpc_commit,
  output logic [7:0]       lpc_commit_data,
  output logic             lpc_rd_vld,
  output logic [7:0]       lpc_rd_data,
  // device mode and locality
  input  wire logic        failure_mode,
  input  wire logic        loc_req,
  input  wire logic [2:0]  loc_req_num,
  output logic [2:0]       active_locality,
  // measurement commands
  output logic             meas_start,
  output logic             meas_data,
  output logic             meas_end,
  output logic [23:0]      meas_dur_cycles,
  output logic             meas_blk_ok,
  // command duration meter
  input  wire logic        execute_trigger_wr,
  input  wire logic        cb_start_wr,
  input  wire logic        cmd_done,
  input  bat_cls_t         cmd_class,
  output logic             response_available,
  output logic             status_valid_flag,
  output logic             command_buffer_control,
  output logic             cmd_over_nominal,
  output logic             cmd_timed_out
);

  bat_core_st_t q;
  bat_core_st_t d;
  logic [2:0]   f;
  logic         sck_r;
  logic         sck_f;
  logic         cs_fall;
  logic         cs_rise;
  logic [7:0]   nbit;
  logic         is_meas;
  logic         lpc_dead;

  bat_tmr_if tif ();

  assign tif.go_fifo = execute_trigger_wr;
  assign tif.go_cb   = cb_start_wr;
  assign tif.done    = cmd_done;
  assign tif.cls     = cmd_class;

  bat_timer #(
    .MS_CYCLES (MS_CYCLES)
  ) u_timer (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .tif     (tif.tmr)
  );

  always_comb begin
    // a filtered pin moves only once the two later stages agree
    f = (q.filt & (q.s2 ^ q.s3)) | (q.s3 & ~(q.s2 ^ q.s3));
    sck_r   = f[0] & ~q.filt[0];
    sck_f   = ~f[0] & q.filt[0];
    cs_fall = ~f[1] & q.filt[1];
    cs_rise = f[1] & ~q.filt[1];
    nbit    = {q.shreg[6:0], f[2]};
    is_meas = (q.op == `BAT_OP_MEAS_START) || (q.op == `BAT_OP_MEAS_DATA) ||
              (q.op == `BAT_OP_MEAS_END);
    lpc_dead = q.lpc_ab | lpc_abort;
    d = q;
    d.s1 = {spi_mosi, spi_cs_n, spi_sck};
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.filt = f;
    d.wr_vld = 1'b0;
    d.meas_start = 1'b0;
    d.meas_data = 1'b0;
    d.meas_end = 1'b0;
    d.lpc_commit = 1'b0;
    d.lpc_rd_vld = 1'b0;

    // parallel cycle: an abort anywhere in the cycle voids it
    if (lpc_cycle_end) begin
      if (lpc_is_read) begin
        d.lpc_rd_vld = 1'b1;
        d.lpc_rd = lpc_dead ? `BAT_ABORT_DATA : lpc_rdata;
      end else if (!lpc_dead) begin
        d.lpc_commit = 1'b1;
        d.lpc_wd = lpc_wdata;
      end
      d.lpc_ab = 1'b0;
    end else if (lpc_abort) begin
      d.lpc_ab = 1'b1;
    end

    // locality moves even in failure mode
    if (loc_req) begin
      d.locality = loc_req_num;
    end

    if (q.timing && q.meas_dur != `BAT_MEAS_DUR_MAX) begin
      d.meas_dur = q.meas_dur + 24'h1;
    end

    case (q.st)
      ST_IDLE: begin
        if (cs_fall) begin
          d.st = ST_HDR;
          d.bitcnt = 3'h0;
          d.miso = 1'b0;
          d.miso_oe_n = 1'b0;
          d.aborted = 1'b0;
        end
      end
      ST_HDR: begin
        if (sck_r) begin
          d.shreg = nbit;
          d.bitcnt = q.bitcnt + 3'h1;
          if (q.bitcnt == `BAT_HDR_LAST) begin
            d.op = nbit[6:0];
            d.dir_rd = nbit[`BAT_HDR_DIR_BIT];
            d.timing = 1'b1;
            d.meas_dur = 24'h0;
            d.meas_cnt = 7'h0;
            d.st = ST_WAIT;
            d.miso = 1'b0;
          end
        end
      end
      ST_DATA: begin
        if (sck_r) begin
          d.shreg = nbit;
          d.bitcnt = q.bitcnt + 3'h1;
          if (q.bitcnt == `BAT_HDR_LAST) begin
            if (q.dir_rd) begin
              d.rdsh = rd_byte;
            end else begin
              // measurement bytes in failure mode are swallowed
              d.wr_vld = ~(is_meas & failure_mode);
              d.wr_byte = nbit;
              if (q.meas_cnt != `BAT_MEAS_CNT_MAX) begin
                d.meas_cnt = q.meas_cnt + 7'h1;
              end
            end
          end
        end
        if (sck_f && q.dir_rd) begin
          d.miso = q.rdsh[7];
          d.rdsh = {q.rdsh[6:0], 1'b0};
        end
      end
      ST_WAIT: begin
        // hold the wait level; the decode check below ends it
        d.miso = 1'b0;
      end
      ST_ABORT: begin
        // nothing is shifted in or out until deselect
        d.miso = 1'b1;
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase

    // decode resolves in the same cycle the wait ends
    if (d.st == ST_WAIT && !decode_wait) begin
      if (abort_req) begin
        d.st = ST_ABORT;
        d.aborted = 1'b1;
        d.miso = 1'b1;
      end else begin
        d.st = ST_DATA;
        d.bitcnt = 3'h0;
        d.rdsh = rd_byte;
      end
    end

    if (cs_rise && q.st != ST_IDLE) begin
      d.st = ST_IDLE;
      d.miso = 1'b0;
      d.miso_oe_n = 1'b1;
      d.timing = 1'b0;
      if (q.st == ST_DATA && !q.aborted && !q.dir_rd && is_meas && !failure_mode) begin
        d.meas_start = (q.op == `BAT_OP_MEAS_START);
        d.meas_data = (q.op == `BAT_OP_MEAS_DATA);
        d.meas_end = (q.op == `BAT_OP_MEAS_END);
      end
      // timing figure only counts for a single full block
      d.meas_blk_ok = (q.op == `BAT_OP_MEAS_DATA) &&
                      (q.meas_cnt == `BAT_MEAS_BLOCK_BYTES);
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
      q.s1 <= `BAT_PIN_RESET;
      q.s2 <= `BAT_PIN_RESET;
      q.s3 <= `BAT_PIN_RESET;
      q.filt <= `BAT_PIN_RESET;
      q.st <= ST_IDLE;
      q.miso_oe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign spi_miso_o             = q.miso;
  assign spi_miso_oe_n          = q.miso_oe_n;
  assign wr_byte                = q.wr_byte;
  assign wr_byte_vld            = q.wr_vld;
  assign lpc_commit             = q.lpc_commit;
  assign lpc_commit_data        = q.lpc_wd;
  assign lpc_rd_vld             = q.lpc_rd_vld;
  assign lpc_rd_data            = q.lpc_rd;
  assign active_locality        = q.locality;
  assign meas_start             = q.meas_start;
  assign meas_data              = q.meas_data;
  assign meas_end               = q.meas_end;
  assign meas_dur_cycles        = q.meas_dur;
  assign meas_blk_ok            = q.meas_blk_ok;
  assign response_available     = tif.resp_avail;
  assign status_valid_flag      = tif.sts_valid;
  assign command_buffer_control = tif.cb_start;
  assign cmd_over_nominal       = tif.over_nom;
  assign cmd_timed_out          = tif.tmo;

  a_lpc_abort_void: assert property (@(posedge clk_sys) disable iff (!reset_n)
    lpc_cycle_end && !lpc_is_read && (lpc_abort || q.lpc_ab) |=> !q.lpc_commit)
    else $error("aborted write was committed");
  a_lpc_abort_ones: assert property (@(posedge clk_sys) disable iff (!reset_n)
    lpc_cycle_end && lpc_is_read && (lpc_abort || q.lpc_ab)
      |=> q.lpc_rd_vld && q.lpc_rd == `BAT_ABORT_DATA)
    else $error("aborted read did not return all ones");
  a_abort_miso_high: assert property (@(posedge clk_sys) disable iff (!reset_n)
    q.st == ST_ABORT |-> q.miso && !q.miso_oe_n)
    else $error("output not held high during abort");
  a_abort_drops_wr: assert property (@(posedge clk_sys) disable iff (!reset_n)
    q.st == ST_ABORT |=> !q.wr_vld)
    else $error("write data passed after abort");
  a_wait_holds_low: assert property (@(posedge clk_sys) disable iff (!reset_n)
    q.st == ST_WAIT |-> !q.miso ##1 (q.st != ST_WAIT || $past(decode_wait)))
    else $error("wait state misbehaved");
  a_fail_meas_quiet: assert property (@(posedge clk_sys) disable iff (!reset_n)
    failure_mode |=> !(q.meas_start || q.meas_data || q.meas_end))
    else $error("measurement acted in failure mode");
  a_locality_moves: assert property (@(posedge clk_sys) disable iff (!reset_n)
    loc_req |=> q.locality == $past(loc_req_num))
    else $error("locality change lost");
  a_meas_dur_runs: assert property (@(posedge clk_sys) disable iff (!reset_n)
    q.timing && q.meas_dur != `BAT_MEAS_DUR_MAX |=> q.meas_dur == $past(q.meas_dur) + 24'h1
      || q.meas_dur == 24'h0)
    else $error("measurement duration stalled");
  c_read_abort: cover property (@(posedge clk_sys) disable iff (!reset_n)
    q.st == ST_ABORT && q.dir_rd ##[1:1000] q.st == ST_IDLE);
  c_meas_block: cover property (@(posedge clk_sys) disable iff (!reset_n)
    q.meas_data && q.meas_blk_ok);
  c_lpc_abort: cover property (@(posedge clk_sys) disable iff (!reset_n)
    lpc_abort ##[1:20] lpc_cycle_end);

endmodule

//--- hdl/bat_params.svh
`ifndef BAT_PARAMS_SVH
`define BAT_PARAMS_SVH

// clock and time base
`define BAT_CLK_PERIOD_NS   10
`define BAT_MS_NS           1000000
`define BAT_MS_CYCLES       ((`BAT_MS_NS) / (`BAT_CLK_PERIOD_NS))

// serial header layout
`define BAT_HDR_DIR_BIT     7
`define BAT_HDR_LAST        3'h7
`define BAT_PIN_RESET       3'h2

// measurement command op codes (header bits 6:0)
`define BAT_OP_MEAS_START   7'h01
`define BAT_OP_MEAS_DATA    7'h02
`define BAT_OP_MEAS_END     7'h03

// measurement data block size in bytes
`define BAT_MEAS_BLOCK_BYTES 7'h40
`define BAT_MEAS_CNT_MAX     7'h7f
`define BAT_MEAS_DUR_MAX     24'hffffff

// abort answer data
`define BAT_ABORT_DATA      8'hff

// command limits in milliseconds
`define BAT_SHORT_NOM_MS    12'h014
`define BAT_SHORT_TMO_MS    12'h2ee
`define BAT_LONG_NOM_MS     12'h2ee
`define BAT_LONG_TMO_MS     12'h7d0
`define BAT_SELF_NOM_MS     12'h3e8
`define BAT_SELF_TMO_MS     12'hbb8
`define BAT_MS_SAT          12'hfff

`endif

//--- hdl/bat_pkg.sv
package bat_pkg;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_HDR   = 5'h02,
    ST_WAIT  = 5'h04,
    ST_DATA  = 5'h08,
    ST_ABORT = 5'h10
  } bat_spi_st_t;

  typedef enum logic [1:0] {
    CLS_SHORT  = 2'h0,
    CLS_LONG   = 2'h1,
    CLS_SELF   = 2'h2,
    CLS_EXEMPT = 2'h3
  } bat_cls_t;

  typedef struct packed {
    logic [2:0]  s1;
    logic [2:0]  s2;
    logic [2:0]  s3;
    logic [2:0]  filt;
    bat_spi_st_t st;
    logic [2:0]  bitcnt;
    logic [7:0]  shreg;
    logic [7:0]  rdsh;
    logic        dir_rd;
    logic [6:0]  op;
    logic        aborted;
    logic        miso;
    logic        miso_oe_n;
    logic [7:0]  wr_byte;
    logic        wr_vld;
    logic        timing;
    logic [23:0] meas_dur;
    logic [6:0]  meas_cnt;
    logic        meas_blk_ok;
    logic        meas_start;
    logic        meas_data;
    logic        meas_end;
    logic        lpc_ab;
    logic        lpc_commit;
    logic [7:0]  lpc_wd;
    logic        lpc_rd_vld;
    logic [7:0]  lpc_rd;
    logic [2:0]  locality;
  } bat_core_st_t;

  typedef struct packed {
    logic        run;
    logic        via_fifo;
    bat_cls_t    cls;
    logic [16:0] tick_cnt;
    logic [11:0] ms;
    logic        resp_avail;
    logic        sts_valid;
    logic        cb_start;
    logic        over_nom;
    logic        tmo;
  } bat_tmr_st_t;

endpackage

//--- hdl/bat_timer.sv
`timescale 1ns/1ps
`include "bat_params.svh"
module bat_timer import bat_pkg::*; #(
  parameter int unsigned MS_CYCLES = `BAT_MS_CYCLES
) (
  // clock and reset
  input  wire logic  clk_sys,
  input  wire logic  reset_n,
  // link to core
  bat_tmr_if.tmr     tif
);

  bat_tmr_st_t q;
  bat_tmr_st_t d;
  logic [11:0] nom_ms;
  logic [11:0] tmo_ms;
  logic        limited;

  always_comb begin
    d = q;
    case (q.cls)
      CLS_LONG: begin
        nom_ms = `BAT_LONG_NOM_MS;
        tmo_ms = `BAT_LONG_TMO_MS;
      end
      CLS_SELF: begin
        nom_ms = `BAT_SELF_NOM_MS;
        tmo_ms = `BAT_SELF_TMO_MS;
      end
      default: begin
        nom_ms = `BAT_SHORT_NOM_MS;
        tmo_ms = `BAT_SHORT_TMO_MS;
      end
    endcase
    // large signature keys run unbounded
    limited = (q.cls != CLS_EXEMPT);
    if (q.run) begin
      if (q.tick_cnt == 17'(MS_CYCLES - 1)) begin
        d.tick_cnt = 17'h0;
        if (q.ms != `BAT_MS_SAT) begin
          d.ms = q.ms + 12'h1;
        end
      end else begin
        d.tick_cnt = q.tick_cnt + 17'h1;
      end
      if (limited && q.ms >= nom_ms) begin
        d.over_nom = 1'b1;
      end
      // force completion at the timeout for every class but CLS_EXEMPT so the host is not left hanging
      if (tif.done || (limited && q.ms >= tmo_ms)) begin
        d.run = 1'b0;
        d.tmo = ~tif.done;
        d.cb_start = 1'b0;
        if (q.via_fifo) begin
          d.resp_avail = 1'b1;
          d.sts_valid = 1'b1;
        end
      end
    end
    // a new start wins over a completion in the same cycle
    if (tif.go_fifo || tif.go_cb) begin
      d.run = 1'b1;
      d.ms = 12'h0;
      d.tick_cnt = 17'h0;
      d.over_nom = 1'b0;
      d.tmo = 1'b0;
      d.cls = tif.cls;
      d.via_fifo = tif.go_fifo;
      if (tif.go_fifo) begin
        d.resp_avail = 1'b0;
        d.sts_valid = 1'b0;
      end
      if (tif.go_cb) begin
        d.cb_start = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tif.resp_avail = q.resp_avail;
  assign tif.sts_valid  = q.sts_valid;
  assign tif.cb_start   = q.cb_start;
  assign tif.over_nom   = q.over_nom;
  assign tif.tmo        = q.tmo;
  assign tif.ms         = q.ms;

  a_go_starts_meter: assert property (@(posedge clk_sys) disable iff (!reset_n)
    tif.go_fifo |=> q.run && q.ms == 12'h0 && !q.resp_avail && !q.sts_valid)
    else $error("start write did not restart the meter");
  a_fifo_done_flags: assert property (@(posedge clk_sys) disable iff (!reset_n)
    q.run && q.via_fifo && tif.done && !tif.go_fifo && !tif.go_cb
      |=> q.resp_avail && q.sts_valid && !q.run)
    else $error("fifo completion did not raise both flags");
  a_cb_done_clears: assert property (@(posedge clk_sys) disable iff (!reset_n)
    q.run && tif.done && !tif.go_fifo && !tif.go_cb |=> !q.cb_start)
    else $error("buffer completion left start set");
  a_tmo_ends_cmd: assert property (@(posedge clk_sys) disable iff (!reset_n)
    q.run && limited && q.ms >= tmo_ms && !tif.go_fifo && !tif.go_cb
      |=> !q.run && (q.tmo || $past(tif.done)))
    else $error("command ran past its timeout");
  a_exempt_no_tmo: assert property (@(posedge clk_sys) disable iff (!reset_n)
    q.run && q.cls == CLS_EXEMPT |=> !q.tmo && !q.over_nom)
    else $error("exempt command was limited");
  c_fifo_cmd: cover property (@(posedge clk_sys) disable iff (!reset_n)
    tif.go_fifo ##[1:1000] (q.run && tif.done));
  c_timeout: cover property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(q.tmo));

endmodule

//--- hdl/bat_tmr_if.sv
`timescale 1ns/1ps
interface bat_tmr_if;
  import bat_pkg::*;
  logic        go_fifo;
  logic        go_cb;
  logic        done;
  bat_cls_t    cls;
  logic        resp_avail;
  logic        sts_valid;
  logic        cb_start;
  logic        over_nom;
  logic        tmo;
  logic [11:0] ms;

  modport tmr  (input go_fifo, go_cb, done, cls,
                output resp_avail, sts_valid, cb_start, over_nom, tmo, ms);
  modport core (output go_fifo, go_cb, done, cls,
                input resp_avail, sts_valid, cb_start, over_nom, tmo, ms);
endinterface

//--- verification/bat_host_model.sv
`timescale 1ns/1ps
module bat_host_model (
  // serial pins
  output logic      spi_sck,
  output logic      spi_cs_n,
  output logic      spi_mosi,
  input  wire logic spi_miso_o,
  input  wire logic spi_miso_oe_n
);
  logic last_q;

  initial begin
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
    last_q = 1'b0;
  end

  // mode 0; a released line shows the inverse of its last level
  task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      spi_mosi = tx[i];
      #80 spi_sck = 1'b1;
      rx[i] = spi_miso_oe_n ? ~last_q : spi_miso_o;
      last_q = rx[i];
      #80 spi_sck = 1'b0;
    end
  endtask

  // clock stands still outside frames; returns AND of read bytes
  task automatic xfer(input logic [7:0] hdr, input int n, input int gap,
                      input logic [7:0] d, output logic [7:0] rd);
    logic [7:0] rx;
    rd = 8'hff;
    spi_cs_n = 1'b0;
    shift(hdr, rx);
    #(gap);
    for (int b = 0; b < n; b++) begin
      shift(d + 8'(b), rx);
      rd &= rx;
    end
    #80 spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
    #320;
  endtask
endmodule

//--- verification/bus_abort_and_command_timing_test.sv
`timescale 1ns/1ps
module bus_abort_and_command_timing_test;
  import bat_pkg::*;
  localparam int MSC = 10;
  logic        clk_sys, reset_n, spi_sck, spi_cs_n, spi_mosi, spi_miso_o, spi_miso_oe_n;
  logic        decode_wait, abort_req, wr_byte_vld, lpc_cycle_end, lpc_abort, lpc_is_read;
  logic        lpc_commit, lpc_rd_vld, failure_mode, loc_req, meas_start, meas_data;
  logic        meas_end, meas_blk_ok, execute_trigger_wr, cb_start_wr, cmd_done;
  logic        response_available, status_valid_flag, command_buffer_control;
  logic        cmd_over_nominal, cmd_timed_out;
  logic [7:0]  rd_byte, wr_byte, lpc_wdata, lpc_rdata, lpc_commit_data, lpc_rd_data;
  logic [2:0]  loc_req_num, active_locality;
  logic [23:0] meas_dur_cycles;
  bat_cls_t    cmd_class;
  logic [23:0] q_wr[$], q_lpc[$], q_meas[$];
  int          num_errors, compares;
  integer      seed;

  bat_core #(.MS_CYCLES(MSC)) i_dut (.clk_sys, .reset_n, .spi_sck, .spi_cs_n, .spi_mosi,
    .spi_miso_o, .spi_miso_oe_n, .decode_wait, .abort_req, .rd_byte, .wr_byte, .wr_byte_vld,
    .lpc_cycle_end, .lpc_abort, .lpc_is_read, .lpc_wdata, .lpc_rdata, .lpc_commit,
    .lpc_commit_data, .lpc_rd_vld, .lpc_rd_data, .failure_mode, .loc_req, .loc_req_num,
    .active_locality, .meas_start, .meas_data, .meas_end, .meas_dur_cycles, .meas_blk_ok,
    .execute_trigger_wr, .cb_start_wr, .cmd_done, .cmd_class, .response_available,
    .status_valid_flag, .command_buffer_control, .cmd_over_nominal, .cmd_timed_out);

  bat_host_model host (.spi_sck, .spi_cs_n, .spi_mosi, .spi_miso_o, .spi_miso_oe_n);

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask

  task automatic check(input string nm, input logic [23:0] exp, input logic [23:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // an empty queue means the result was not expected at all
  task automatic take(ref logic [23:0] q[$], input string nm, input logic [23:0] got);
    check(nm, q.size() > 0 ? q.pop_front() : 24'hx, got);
  endtask

  task automatic wrap_up;
    check("leftover", 24'h0, 24'(q_wr.size() + q_lpc.size() + q_meas.size()));
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    if (reset_n) begin
      if (wr_byte_vld) take(q_wr, "wr_byte", {16'h0, wr_byte});
      if (lpc_commit) take(q_lpc, "lpc_commit", {16'h0, lpc_commit_data});
      if (lpc_rd_vld) take(q_lpc, "lpc_read", {16'h1, lpc_rd_data});
      if (meas_start | meas_data | meas_end)
        take(q_meas, "meas", {21'h0, meas_end, meas_data, meas_start});
    end
  end

  // abort arrives one cycle before the end, so it must be held
  task automatic lpc(input logic rd, input logic ab);
    logic [7:0] d;
    d = 8'($random(seed));
    lpc_abort = ab;
    tick;
    lpc_abort = 1'b0;
    lpc_cycle_end = 1'b1;
    lpc_is_read = rd;
    lpc_wdata = d;
    lpc_rdata = ~d;
    if (rd) q_lpc.push_back({16'h1, ab ? 8'hff : ~d});
    else if (!ab) q_lpc.push_back({16'h0, d});
    tick;
    lpc_cycle_end = 1'b0;
  endtask

  task automatic spi(input logic [7:0] hdr, input int n, input logic ab, input int gap);
    logic [7:0] d, rd;
    logic       ms;
    int         e;
    d = 8'($random(seed));
    rd_byte = 8'($random(seed));
    ms = !hdr[7] && hdr[6:0] inside {7'h1, 7'h2, 7'h3} && !ab;
    e = 16 + 128 * n;
    abort_req = ab;
    decode_wait = gap > 0;
    if (!hdr[7] && !ab && !(ms && failure_mode))
      for (int b = 0; b < n; b++) q_wr.push_back({16'h0, d + 8'(b)});
    if (ms && !failure_mode) q_meas.push_back(24'h1 << (hdr[1:0] - 2'h1));
    fork
      host.xfer(hdr, n, gap, d, rd);
      if (gap > 0) begin
        #1750;
        check("wait_miso", 24'h0, {22'h0, spi_miso_oe_n, spi_miso_o});
        decode_wait = 1'b0;
      end
    join
    if (hdr[7]) check("spi_read", {16'h0, ab ? 8'hff : rd_byte}, {16'h0, rd});
    if (ms && !failure_mode) begin
      check("blk_ok", 24'(hdr[1:0] == 2'h2 && n == 64), 24'(meas_blk_ok));
      check("meas_dur", 24'h1, 24'(int'(meas_dur_cycles) >= e - 4
                                  && int'(meas_dur_cycles) <= e + 4));
    end
    abort_req = 1'b0;
    tick;
  endtask

  task automatic meter(input int c, input logic cb, input int done_at, input int nom,
                       input int tmo);
    int   n, lo;
    logic fin;
    cmd_class = bat_cls_t'(c);
    execute_trigger_wr = !cb;
    cb_start_wr = cb;
    tick;
    execute_trigger_wr = 1'b0;
    cb_start_wr = 1'b0;
    tick;
    check("started", 24'(cb), 24'(cb ? command_buffer_control
                                     : response_available | status_valid_flag));
    n = 1;
    fin = 1'b0;
    while (!fin && n < 32000) begin
      cmd_done = n == done_at;
      tick;
      n++;
      fin = cb ? command_buffer_control === 1'b0
               : response_available === 1'b1 && status_valid_flag === 1'b1;
    end
    cmd_done = 1'b0;
    if (!fin) begin
      check("meter_bound", 24'h1, 24'h0);
      wrap_up;
    end
    lo = done_at > 0 ? done_at : tmo * MSC;
    check("cmd_time", 24'h1, 24'(n >= lo && n <= lo + MSC + 4));
    check("timed_out", 24'(done_at == 0), 24'(cmd_timed_out));
    check("over_nom", 24'(n > nom * MSC), 24'(cmd_over_nominal));
  endtask

  int t_c[7] = '{0, 0, 0, 1, 2, 1, 3};
  int t_d[7] = '{150, 250, 0, 0, 0, 7000, 8000};
  int t_n[7] = '{20, 20, 20, 750, 1000, 750, 99999};
  int t_t[7] = '{750, 750, 750, 2000, 3000, 2000, 0};

  initial begin
    seed = 32'ha93d0e65;
    {decode_wait, abort_req, lpc_cycle_end, lpc_abort, lpc_is_read} = '0;
    {failure_mode, loc_req, execute_trigger_wr, cb_start_wr, cmd_done} = '0;
    {rd_byte, lpc_wdata, lpc_rdata, loc_req_num} = '0;
    cmd_class = CLS_SHORT;
    num_errors = 0;
    compares = 0;
    reset_n = 1'b0;
    repeat (12) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    repeat (4) tick;
    for (int i = 0; i < 8; i++) lpc(i[0], i[1]);
    $display("test parallel aborts done");
    spi(8'h10, 3, 1'b0, 0);
    spi(8'h10, 3, 1'b1, 0);
    spi(8'h90, 2, 1'b0, 0);
    spi(8'h90, 3, 1'b1, 0);
    spi(8'h90, 2, 1'b1, 800);
    $display("test serial aborts done");
    spi(8'h01, 0, 1'b0, 0);
    spi(8'h02, 64, 1'b0, 0);
    spi(8'h02, 63, 1'b0, 0);
    spi(8'h03, 1, 1'b0, 0);
    $display("test measurement commands done");
    failure_mode = 1'b1;
    for (int i = 1; i < 4; i++) spi(8'(i), 2, 1'b0, 0);
    for (int i = 4; i >= 0; i--) begin
      loc_req = 1'b1;
      loc_req_num = 3'(i);
      tick;
      loc_req = 1'b0;
      tick;
      check("locality", 24'(i), 24'(active_locality));
    end
    for (int i = 0; i < 4; i++) lpc(i[0], i[1]);
    failure_mode = 1'b0;
    $display("test failure mode done");
    for (int i = 0; i < 7; i++) meter(t_c[i], i[0], t_d[i], t_n[i], t_t[i]);
    $display("test command meter done");
    repeat (4) tick;
    wrap_up;
  end
endmodule
